// file: design/sep_device.sv
// Device end: serial EEPROM pin control, decoder and array
//
// What this block does
// - Select high selects; low means standby
// - Started programming completes despite select falling
// - Master holds select low 250 ns
// - Select low holds control state in reset
// - Sample input bits on serial clock rise
// - Read data advances on each clock rise
// - Clock may pause anywhere; progress kept
// - Clock ignored while select low
// - Before start, clocks change nothing
// - Programming runs without serial clocks
// - Execute only after all bits arrive
// - After last bit, wait for start
// - Select low between instructions, except sequential read
// - Status shown until next start bit
// - Width strap high gives x16, low x8
// - Protect input low blocks all programming
// - Start is first rise with input high
// - Status low while busy, high ready
// - Programming disabled after reset until enabled
// - Read gives dummy zero then word
`timescale 1ns/10ps
`default_nettype none
module sep_device #(
  parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES,
  parameter int ADDR_W16    = sep_pkg::ADDR_W16
)(
  input  wire logic    core_clk,
  input  wire logic    rst,
  sep_link_if.device   link,
  input  wire logic    word_width_strap,
  input  wire logic    program_protect_input,
  output logic         prog_busy,
  output logic         write_enabled
);
  import sep_pkg::*;

  // ****************************************************************
  // Sizes and types
  // ****************************************************************
  localparam int AW8    = ADDR_W16 + 1;
  localparam int SRW    = OP_W + AW8 + DATA_W16;
  localparam int CNT_W  = $clog2(SRW + 1);
  localparam int BUSY_W = $clog2(PROG_CYCLES + 1);
  localparam int WORDS  = 2 ** ADDR_W16;
  typedef enum logic [1:0] {ST_WAIT, ST_CMD, ST_READ, ST_STATUS}
    sep_dev_state_type;
  sep_dev_state_type state;
  sep_dev_state_type next_state;
  logic [4:0]        pin_meta;
  logic [4:0]        pin_sync;
  logic              sclk_last;
  logic [CNT_W-1:0]  bit_cnt;
  logic [SRW-1:0]    shift_sr;
  logic              all_q;
  logic [AW8-1:0]    addr_q;
  logic [15:0]       rd_sr;
  logic [CNT_W-1:0]  rd_left;
  logic [AW8-1:0]    rd_addr;
  logic [BUSY_W-1:0] busy_cnt;
  logic              so;
  logic              so_oe;
  logic [15:0]       mem [WORDS];

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Both straps pass the same two stages as the link pins
  always_ff @(posedge core_clk)
  begin
    pin_meta <= {link.select, link.sclk, link.serial_in,
                 word_width_strap, program_protect_input};
    pin_sync <= pin_meta;
    sclk_last <= rst ? 1'b0 : pin_sync[3];
  end

  wire sel     = pin_sync[4];
  wire sclk_s  = pin_sync[3];
  wire sin     = pin_sync[2];
  wire x16     = pin_sync[1];
  wire prot_ok = pin_sync[0];
  wire rise    = sel & sclk_s & ~sclk_last;

  // ****************************************************************
  // Frame decode
  // ****************************************************************
  wire [CNT_W-1:0] aw = x16 ? CNT_W'(ADDR_W16) : CNT_W'(AW8);
  wire [CNT_W-1:0] dw = x16 ? CNT_W'(DATA_W16) : CNT_W'(DATA_W8);
  wire [AW8-1:0] amask = x16 ? AW8'({ADDR_W16{1'b1}}) : {AW8{1'b1}};
  wire [CNT_W-1:0] n_bits = bit_cnt + 1'b1;
  wire [SRW-1:0] next_sr = {shift_sr[SRW-2:0], sin};
  wire [1:0] op_f = next_sr[aw + 1'b1 -: 2];
  wire [1:0] sub_f = next_sr[aw - 1'b1 -: 2];
  wire [AW8-1:0] addr_f = next_sr[AW8-1:0] & amask;
  wire [15:0] data_d = next_sr[15:0] & (x16 ? MASK_X16 : MASK_X8);
  wire addr_done = n_bits == CNT_W'(OP_W) + aw;
  wire data_done = n_bits == CNT_W'(OP_W) + aw + dw;
  wire in_cmd = (state == ST_CMD) & rise;
  wire exec_addr = in_cmd & addr_done;
  wire exec_data = in_cmd & data_done;
  wire is_special = op_f == OP_SPECIAL;
  wire need_data = (op_f == OP_WRITE) | (is_special & sub_f == SUB_WRITE_ALL);
  wire en_cmd = exec_addr & is_special & sub_f == SUB_ERASE_WRITE_ENABLE_CMD;
  wire dis_cmd = exec_addr & is_special & sub_f == SUB_ERASE_WRITE_DISABLE_CMD;
  wire erase_op = (op_f == OP_ERASE) | (is_special & sub_f == SUB_ERASE_ALL);

  // ****************************************************************
  // Programming request
  // ****************************************************************
  wire prog_req = (exec_addr & erase_op) | exec_data;
  // Requests rejected by enable or protect still enter status, so the poll sees ready at once
  wire prog_fire = prog_req & write_enabled & prot_ok
                   & (busy_cnt == '0);
  wire p_all = exec_data ? all_q : is_special;
  wire [AW8-1:0] p_addr = exec_data ? addr_q : addr_f;
  wire [15:0] p_val = exec_data ? data_d : ERASED_WORD;
  wire [15:0] p_word = x16 ? p_val : {p_val[7:0], p_val[7:0]};
  wire [1:0] p_lanes = (x16 | p_all) ? 2'h3 : (p_addr[0] ? 2'h1 : 2'h2);
  wire [ADDR_W16-1:0] p_idx = x16 ? p_addr[ADDR_W16-1:0] : p_addr[AW8-1:1];
  wire [BUSY_W-1:0] next_busy = prog_fire ? BUSY_W'(PROG_CYCLES) :
                    (busy_cnt != '0) ? busy_cnt - 1'b1 : '0;

  // ****************************************************************
  // Read fetch
  // ****************************************************************
  wire [AW8-1:0] rd_next = (rd_addr + 1'b1) & amask;
  wire [AW8-1:0] fa = (state == ST_CMD) ? addr_f : rd_next;
  wire [15:0] fw = mem[x16 ? fa[ADDR_W16-1:0] : fa[AW8-1:1]];
  wire [15:0] fetch = x16 ? fw : {(fa[0] ? fw[7:0] : fw[15:8]), 8'h00};
  wire rd_load = (state == ST_CMD) & (next_state == ST_READ);
  wire rd_step = (state == ST_READ) & rise;

  // ****************************************************************
  // Control state machine
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      ST_WAIT:
        if (rise & sin)
          next_state = ST_CMD;
      ST_CMD:
        if (prog_req)
          next_state = ST_STATUS;
        else if (exec_addr & op_f == OP_READ)
          next_state = ST_READ;
        else if (exec_addr & ~need_data)
          next_state = ST_WAIT;
      ST_READ:
        next_state = ST_READ;
      ST_STATUS:
        if (rise & sin)
          next_state = ST_CMD;
      default:
        next_state = ST_WAIT;
    endcase
    if (~sel)
      next_state = ST_WAIT;
  end

  // Nothing here moves without a rise, so a paused clock keeps progress
  always_ff @(posedge core_clk)
  begin
    if (rst | (next_state == ST_CMD & state != ST_CMD))
    begin
      bit_cnt  <= '0;
      shift_sr <= '0;
    end
    else if (in_cmd)
    begin
      bit_cnt  <= n_bits;
      shift_sr <= next_sr;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      all_q  <= 1'b0;
      addr_q <= '0;
    end
    else if (exec_addr)
    begin
      all_q  <= is_special;
      addr_q <= addr_f;
    end
  end

  // ****************************************************************
  // Erase/write enable and busy timer
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
      write_enabled <= 1'b0;
    else if (en_cmd)
      write_enabled <= 1'b1;
    else if (dis_cmd)
      write_enabled <= 1'b0;
  end

  // Timer ignores select and clock, so the cycle always finishes
  always_ff @(posedge core_clk)
  begin
    busy_cnt  <= rst ? '0 : next_busy;
    prog_busy <= rst ? 1'b0 : (next_busy != '0);
  end

  // Array is not reset: it models retained contents
  always_ff @(posedge core_clk)
  begin
    if (prog_fire)
    begin
      for (int w = 0; w < WORDS; w++)
      begin
        if (p_all | (p_idx == ADDR_W16'(w)))
        begin
          if (p_lanes[1])
            mem[w][15:8] <= p_word[15:8];
          if (p_lanes[0])
            mem[w][7:0] <= p_word[7:0];
        end
      end
    end
  end

  // ****************************************************************
  // Read shifter
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_sr   <= '0;
      rd_left <= '0;
      rd_addr <= '0;
    end
    else if (rd_load | (rd_step & rd_left == CNT_W'(1)))
    begin
      rd_sr   <= fetch;
      rd_left <= dw;
      rd_addr <= rd_load ? addr_f : rd_next;
    end
    else if (rd_step)
    begin
      rd_sr   <= {rd_sr[14:0], 1'b0};
      rd_left <= rd_left - 1'b1;
    end
  end

  // ****************************************************************
  // Serial output
  // ****************************************************************
  wire next_oe = (next_state == ST_READ) | (next_state == ST_STATUS);
  wire next_so = (next_state == ST_STATUS) ? (next_busy == '0) :
                 rd_load ? 1'b0 :
                 rd_step ? rd_sr[15] : so;

  always_ff @(posedge core_clk)
  begin
    state <= rst ? ST_WAIT : next_state;
    so    <= rst ? 1'b0 : next_so;
    so_oe <= rst ? 1'b0 : next_oe;
  end

  assign link.serial_out    = so;
  assign link.serial_out_oe = so_oe;
endmodule // sep_device
`default_nettype wire

// file: common/sep_pkg.sv
// Shared constants for both ends of the serial EEPROM pin link
package sep_pkg;
  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int ADDR_W16 = 10;
  localparam int ADDR_W8  = 11;
  localparam int DATA_W16 = 16;
  localparam int DATA_W8  = 8;
  localparam int OP_W     = 2;
  localparam int SHIFT_W  = OP_W + ADDR_W8 + DATA_W16;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] MASK_X16    = 16'hFFFF;
  localparam logic [15:0] MASK_X8     = 16'h00FF;

  // ****************************************************************
  // Opcodes and sub-commands
  // ****************************************************************
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_ERASE   = 2'h3;
  localparam logic [1:0] SUB_ERASE_WRITE_DISABLE_CMD = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL               = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL               = 2'h2;
  localparam logic [1:0] SUB_ERASE_WRITE_ENABLE_CMD  = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS        = 20;
  localparam int PROG_NS       = 3000000;
  localparam int PROG_CYCLES   = PROG_NS / CLK_NS;
  localparam int CS_LOW_NS     = 250;
  localparam int CS_LOW_CYCLES = (CS_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF     = 8;
endpackage

// file: common/sep_link_if.sv
// Pin-level link between the bus master and the EEPROM device
`timescale 1ns/10ps
`default_nettype none
interface sep_link_if;
  logic select;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic serial_out_level;

  // Undriven output pin reads as pulled high
  assign serial_out_level = serial_out_oe ? serial_out : 1'b1;

  modport master (output select, output sclk, output serial_in,
                  input serial_out_level);
  modport device (input select, input sclk, input serial_in,
                  output serial_out, output serial_out_oe);
endinterface
`default_nettype wire

// file: design/sep_master.sv
// Master end: drives select, clock and data, reads into a buffer
`timescale 1ns/10ps
`default_nettype none
module sep_master #(
  parameter int SCLK_HALF  = sep_pkg::SCLK_HALF,
  parameter int FIFO_DEPTH = 2
)(
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  sep_link_if.master                        link,
  input  wire logic                         cmd_valid,
  output logic                              cmd_ready,
  input  wire logic [1:0]                   cmd_op,
  input  wire logic [sep_pkg::ADDR_W8-1:0]  cmd_addr,
  input  wire logic [sep_pkg::DATA_W16-1:0] cmd_data,
  input  wire logic                         cmd_x16,
  input  wire logic [7:0]                   cmd_words,
  output logic                              rd_valid,
  input  wire logic                         rd_ready,
  output logic [sep_pkg::DATA_W16-1:0]      rd_data
);
  import sep_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int TXW   = 1 + SHIFT_W;
  localparam int HC_W  = $clog2(SCLK_HALF + 1);
  localparam int GAP_W = $clog2(CS_LOW_CYCLES + 1);
  localparam int PW    = $clog2(FIFO_DEPTH);

  typedef enum logic [2:0] {M_IDLE, M_SHIFT, M_READ, M_TAIL, M_GAP}
    sep_mst_state_type;

  sep_mst_state_type state;
  logic [HC_W-1:0]   hc;
  logic [GAP_W-1:0]  gap_cnt;
  logic              sel_q;
  logic              sclk_q;
  logic              sin_q;
  logic              so_meta;
  logic              so_s;
  logic [TXW-1:0]    tx;
  logic [4:0]        tx_left;
  logic              rd_q;
  logic              poll_q;
  logic              dummy_q;
  logic [4:0]        dw_q;
  logic [4:0]        bit_pos;
  logic [7:0]        words_left;
  logic [15:0]       rx;
  logic [15:0]       fifo_mem [FIFO_DEPTH];
  logic [PW-1:0]     wr_ptr;
  logic [PW-1:0]     rd_ptr;
  logic [PW:0]       fifo_cnt;

  // ****************************************************************
  // Command framing
  // ****************************************************************
  wire [4:0] aw = cmd_x16 ? 5'(ADDR_W16) : 5'(ADDR_W8);
  wire [4:0] dw = cmd_x16 ? 5'(DATA_W16) : 5'(DATA_W8);
  wire [1:0] sub = cmd_addr[aw - 1'b1 -: 2];
  wire is_special = cmd_op == OP_SPECIAL;
  wire wants_data = (cmd_op == OP_WRITE) | (is_special & sub == SUB_WRITE_ALL);
  wire is_prog = wants_data | (cmd_op == OP_ERASE)
                 | (is_special & sub == SUB_ERASE_ALL);
  wire [4:0] dlen = wants_data ? dw : 5'h00;
  wire [15:0] dmask = wants_data ? (cmd_x16 ? MASK_X16 : MASK_X8) : 16'h0000;
  wire [TXW-1:0] tx_init = TXW'(cmd_data & dmask)
                           | (TXW'({1'b1, cmd_op}) << (aw + dlen))
                           | (TXW'(cmd_addr) << dlen);
  wire take = cmd_valid & cmd_ready;

  // ****************************************************************
  // Clock divider and read buffer
  // ****************************************************************
  wire running = (state == M_SHIFT) | (state == M_READ) | (state == M_TAIL);
  wire in_ready = fifo_cnt != (PW+1)'(FIFO_DEPTH);
  // Full buffer freezes the divider: the clock just pauses mid-read
  wire stall = (state == M_READ) & ~in_ready;
  wire tick = running & ~stall & (hc == HC_W'(SCLK_HALF - 1));
  wire fall = tick & sclk_q;
  wire push = (state == M_READ) & fall & ~dummy_q
              & (bit_pos == dw_q - 1'b1);
  wire pop = rd_valid & rd_ready;
  wire [PW:0] next_cnt = fifo_cnt + (PW+1)'(push) - (PW+1)'(pop);
  wire gap_done = gap_cnt == GAP_W'(CS_LOW_CYCLES - 1);

  always_ff @(posedge core_clk)
  begin
    so_meta <= link.serial_out_level;
    so_s    <= so_meta;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst | ~running | tick)
      hc <= '0;
    else if (~stall)
      hc <= hc + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      fifo_mem[wr_ptr] <= {rx[14:0], so_s};
  end

  always_ff @(posedge core_clk)
  begin
    wr_ptr   <= rst ? '0 : wr_ptr + PW'(push);
    rd_ptr   <= rst ? '0 : rd_ptr + PW'(pop);
    fifo_cnt <= rst ? '0 : next_cnt;
    rd_valid <= rst ? 1'b0 : (next_cnt != '0);
  end

  assign rd_data = fifo_mem[rd_ptr];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= M_GAP;
      sel_q <= 1'b0;
      sclk_q <= 1'b0;
      sin_q <= 1'b0;
      gap_cnt <= '0;
      cmd_ready <= 1'b0;
    end
    else
    begin
      case (state)
        M_IDLE:
          if (take)
          begin
            state <= M_SHIFT;
            sel_q <= 1'b1;
            sin_q <= 1'b1;
            cmd_ready <= 1'b0;
          end
        M_SHIFT:
          if (tick & ~sclk_q)
          begin
            sclk_q <= 1'b1;
            if (tx_left == 5'h01)
              state <= rd_q ? M_READ : M_TAIL;
          end
          else if (fall)
          begin
            sclk_q <= 1'b0;
            sin_q <= tx[tx_left - 1'b1];
          end
        M_READ:
          if (tick)
          begin
            sclk_q <= ~sclk_q;
            if (push & words_left == 8'h01)
              state <= M_TAIL;
          end
        M_TAIL:
          if (fall)
            sclk_q <= 1'b0;
          else if (tick & (~poll_q | so_s))
          begin
            state <= M_GAP;
            sel_q <= 1'b0;
            gap_cnt <= '0;
          end
        M_GAP:
          if (gap_done)
          begin
            state <= M_IDLE;
            cmd_ready <= 1'b1;
          end
          else
            gap_cnt <= gap_cnt + 1'b1;
        default:
          state <= M_GAP;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (take)
    begin
      tx <= tx_init;
      tx_left <= 5'h03 + aw + dlen;
      rd_q <= cmd_op == OP_READ;
      poll_q <= is_prog;
      dw_q <= dw;
      words_left <= cmd_words;
      dummy_q <= 1'b1;
      bit_pos <= '0;
    end
    else if ((state == M_SHIFT) & tick & ~sclk_q)
      tx_left <= tx_left - 1'b1;
    else if ((state == M_READ) & fall)
    begin
      dummy_q <= 1'b0;
      if (~dummy_q)
      begin
        rx <= {rx[14:0], so_s};
        bit_pos <= push ? 5'h00 : bit_pos + 1'b1;
        words_left <= words_left - 8'(push);
      end
    end
  end

  assign link.select    = sel_q;
  assign link.sclk      = sclk_q;
  assign link.serial_in = sin_q;
endmodule // sep_master
`default_nettype wire

// file: bench/sep_link_props.sv
// Checker: concurrent properties on the master/device pin link
`timescale 1ns/10ps
`default_nettype none
module sep_link_props #(
  parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic select,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic serial_out_level,
  input wire logic prog_busy
);
  import sep_pkg::*;
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic        sclk_d;
  logic [3:0]  since_rise;
  logic [17:0] busy_len;
  logic [7:0]  low_len;
  wire         sclk_rise = sclk & ~sclk_d;
  wire  [3:0]  sat_rise = {3'h0, since_rise != 4'hF};
  wire  [3:0]  next_since_rise = sclk_rise ? 4'h0 : since_rise + sat_rise;
  wire  [17:0] next_busy_len = prog_busy ? busy_len + 18'h00001 : 18'h00000;
  wire  [7:0]  sat_low = {7'h00, low_len != 8'hFF};
  wire  [7:0]  next_low_len = select ? 8'h00 : low_len + sat_low;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sclk_d <= 1'b0;
      since_rise <= 4'hF;
      busy_len <= 18'h00000;
      low_len <= 8'h00;
    end
    else
    begin
      sclk_d <= sclk;
      since_rise <= next_since_rise;
      busy_len <= next_busy_len;
      low_len <= next_low_len;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  // Sync latency of the device allows a few cycles after each rise
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  busy_span_a: assert property ($fell(prog_busy)
    |-> busy_len == PROG_CYCLES) else $error("busy span wrong");
  busy_low_a: assert property (prog_busy && $past(prog_busy)
    && serial_out_oe |-> !serial_out) else $error("status not busy");
  ready_show_a: assert property ($fell(prog_busy) && select
    |-> ##[0:3] serial_out_level) else $error("ready not shown");
  standby_a: assert property (!select [*5]
    |-> !serial_out_oe) else $error("driving while deselected");
  oe_cause_a: assert property ($rose(serial_out_oe)
    |-> select && since_rise <= 4'h5) else $error("output without edge");
  read_step_a: assert property ($changed(serial_out)
    && serial_out_oe && $past(serial_out_oe) && !prog_busy
    && !$past(prog_busy) && !$past(prog_busy, 2) && !$past(prog_busy, 3)
    |-> since_rise <= 4'h5) else $error("data moved without edge");
  din_setup_a: assert property ($rose(sclk)
    |-> $stable(serial_in)) else $error("input moved at rise");
  cs_gap_a: assert property ($rose(select)
    |-> low_len >= CS_LOW_CYCLES) else $error("select gap short");
endmodule // sep_link_props
`default_nettype wire

// file: bench/testbench.sv
// Bench: master and device joined over the pin link
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sep_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int PROG_SIM = 50;
  logic        core_clk = 1'b0;
  logic        rst;
  logic        strap;
  logic        protect;
  logic        prog_busy;
  logic        write_enabled;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [1:0]  cmd_op;
  logic [10:0] cmd_addr;
  logic [15:0] cmd_data;
  logic        cmd_x16;
  logic [7:0]  cmd_words;
  logic        rd_valid;
  logic        rd_ready;
  logic [15:0] rd_data;
  logic        taken;
  logic        busy_d;
  logic [15:0] n_busy;
  logic [15:0] q[$];
  int          fails = 0;
  int          cmp_count = 0;

  sep_link_if link();
  sep_master i_sep_master (.core_clk(core_clk), .rst(rst),
    .link(link.master), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_x16(cmd_x16), .cmd_words(cmd_words), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));
  sep_device #(.PROG_CYCLES(PROG_SIM)) i_sep_device (.core_clk(core_clk),
    .rst(rst), .link(link.device), .word_width_strap(strap),
    .program_protect_input(protect), .prog_busy(prog_busy),
    .write_enabled(write_enabled));
  sep_link_props #(.PROG_CYCLES(PROG_SIM)) i_props (.core_clk(core_clk),
    .rst(rst), .select(link.select), .sclk(link.sclk),
    .serial_in(link.serial_in), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe),
    .serial_out_level(link.serial_out_level), .prog_busy(prog_busy));

  always #10 core_clk = ~core_clk;

  // Counts programming cycles and collects read words
  always @(posedge core_clk)
  begin
    taken <= cmd_valid & cmd_ready;
    busy_d <= prog_busy;
    if (rst)
      n_busy <= 16'h0000;
    else if (prog_busy && !busy_d)
      n_busy <= n_busy + 16'h0001;
    if (rd_valid && rd_ready)
      q.push_back(rd_data);
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n = 0;
    while (cmd_ready !== 1'b1 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("idle", 16'h0001, {15'h0000, cmd_ready});
  endtask

  task automatic issue(input logic [1:0] op, input logic [10:0] addr,
                       input logic [15:0] data, input logic [7:0] words);
    int n = 0;
    @(negedge core_clk);
    cmd_op = op;
    cmd_addr = addr;
    cmd_data = data;
    cmd_words = words;
    cmd_valid = 1'b1;
    while (taken !== 1'b1 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    cmd_valid = 1'b0;
    if (op != OP_READ)
      wait_ready();
  endtask

  // Stall holds the reader off so the two-entry buffer fills
  task automatic rd(input logic [10:0] addr, input logic [7:0] words,
                    input int stall);
    q.delete();
    rd_ready = 1'b0;
    issue(OP_READ, addr, 16'h0000, words);
    repeat (stall) @(negedge core_clk);
    rd_ready = 1'b1;
    wait_ready();
  endtask

  task automatic rdw(input logic [10:0] addr, input logic [15:0] exp,
                     input logic [15:0] mask);
    rd(addr, 8'h01, 0);
    chk("read data", exp & mask, q[0] & mask);
  endtask

  function automatic logic [10:0] sp(input logic [1:0] sub);
    return cmd_x16 ? {1'b0, sub, 8'h00} : {sub, 9'h000};
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    strap = 1'b1;
    protect = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = 11'h000;
    cmd_data = 16'h0000;
    cmd_x16 = 1'b1;
    cmd_words = 8'h01;
    rd_ready = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    wait_ready();
    chk("enable flag", 16'h0000, {15'h0000, write_enabled});
    issue(OP_WRITE, 11'h003, 16'h1234, 8'h01);
    chk("prog cycles", 16'h0000, n_busy);
    issue(OP_SPECIAL, sp(SUB_ERASE_WRITE_ENABLE_CMD), 16'h0000, 8'h01);
    chk("enable flag", 16'h0001, {15'h0000, write_enabled});
    issue(OP_SPECIAL, sp(SUB_WRITE_ALL), 16'h5A5A, 8'h01);
    rdw(11'h003, 16'h5A5A, MASK_X16);
    issue(OP_WRITE, 11'h003, 16'hA55A, 8'h01);
    issue(OP_WRITE, 11'h004, 16'h0F0F, 8'h01);
    issue(OP_ERASE, 11'h005, 16'h0000, 8'h01);
    chk("prog cycles", 16'h0004, n_busy);
    rd(11'h003, 8'h03, 1500);
    chk("word count", 16'h0003, 16'(q.size()));
    chk("seq word", 16'hA55A, q[0]);
    chk("seq word", 16'h0F0F, q[1]);
    chk("seq word", ERASED_WORD, q[2]);
    protect = 1'b0;
    issue(OP_WRITE, 11'h003, 16'h1111, 8'h01);
    protect = 1'b1;
    chk("prog cycles", 16'h0004, n_busy);
    rdw(11'h003, 16'hA55A, MASK_X16);
    issue(OP_SPECIAL, sp(SUB_ERASE_WRITE_DISABLE_CMD), 16'h0000, 8'h01);
    chk("enable flag", 16'h0000, {15'h0000, write_enabled});
    issue(OP_ERASE, 11'h004, 16'h0000, 8'h01);
    rdw(11'h004, 16'h0F0F, MASK_X16);
    strap = 1'b0;
    cmd_x16 = 1'b0;
    rdw(11'h006, 16'h00A5, MASK_X8);
    rdw(11'h007, 16'h005A, MASK_X8);
    rdw(11'h008, 16'h000F, MASK_X8);
    strap = 1'b1;
    cmd_x16 = 1'b1;
    issue(OP_SPECIAL, sp(SUB_ERASE_WRITE_ENABLE_CMD), 16'h0000, 8'h01);
    issue(OP_SPECIAL, sp(SUB_ERASE_ALL), 16'h0000, 8'h01);
    rdw(11'h004, ERASED_WORD, MASK_X16);
    final_report();
  end

  // About 9k cycles expected; cut off well beyond that
  initial
  begin
    #1000000;
    fails++;
    $display("CHECK FAILED watchdog expected done seen hang");
    final_report();
  end
endmodule // testbench
`default_nettype wire
